// ### core/s2p_pkg.sv
// Shared constants for the serial-to-parallel driver core.
package s2p_pkg;

	// ==========================================================
	// Geometry
	localparam int CHANNELS = 64;
	localparam int COUNT_WIDTH = 16;
	localparam int ADDR_WIDTH = 5;
	localparam int DATA_WIDTH = 32;

	// ==========================================================
	// Register byte offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_SHIFT_LO = 5'h08;
	localparam logic [4:0] REG_SHIFT_HI = 5'h0c;
	localparam logic [4:0] REG_LATCH_LO = 5'h10;
	localparam logic [4:0] REG_LATCH_HI = 5'h14;
	localparam logic [4:0] REG_EDGE_COUNT = 5'h18;

	// ==========================================================
	// Control fields
	localparam int CTRL_COUNT_CLEAR = 0;
	localparam int CTRL_COUNT_FREEZE = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// ==========================================================
	// Status fields, one per filtered pin level
	localparam int STAT_SHIFT_CLOCK = 0;
	localparam int STAT_LATCH_GATE = 1;
	localparam int STAT_OUTPUT_FORCE = 2;
	localparam int STAT_INVERT_SELECT = 3;
	localparam int STAT_SHIFT_WAY = 4;
	localparam int STAT_WIDTH = 5;

	// ==========================================================
	// Reset values
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
	localparam logic SHIFT_CLOCK_PREV_RESET = 1'b1;

	// ==========================================================
	// Bus answer states, Gray coded
	typedef enum logic [1:0] {
		S2P_BUS_IDLE = 2'b00,
		S2P_BUS_ANSWER = 2'b01
	} s2p_bus_state_t;

endpackage

// ### core/s2p_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none

module s2p_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] next_level;

	// ==========================================================
	// Filter
	// A level counts only once the second and third stages agree.
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_level[i] = (stage2[i] == stage3[i]) ? stage2[i] : level[i];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level <= next_level;
		end
	end

	assign level_out = level;

endmodule

`default_nettype wire

// ### core/s2p_outstage.sv
// Blanking and polarity stage in front of the driver outputs.
`timescale 1ns/100ps
`default_nettype none

module s2p_outstage #(
	parameter int WIDTH = 64
) (
	input wire logic output_force_in,
	input wire logic invert_select_in,
	input wire logic [WIDTH-1:0] latch_in,
	output logic [WIDTH-1:0] drive_out
);

	// ==========================================================
	// Output selection
	always_comb begin
		if (!output_force_in) begin
			drive_out = {WIDTH{~invert_select_in}};
		end else if (invert_select_in) begin
			drive_out = latch_in;
		end else begin
			drive_out = ~latch_in;
		end
	end

endmodule

`default_nettype wire

// ### core/s2p_driver.sv
// Serial-to-parallel driver core with shift register, latches and bus.
// Notes on behaviour
// - Sixty-four shift stages, each with a latch feeding one driver output.
// - Way select low: port A in, port B out, data moves 64 toward 1.
// - Way select high: port B in, port A out, data moves 1 toward 64.
// - Shifting advances one stage only on each shift clock rising edge.
// - Latch gate, force and invert never affect shifting.
// - Latch gate high makes latches follow their stages continuously.
// - Latch gate falling captures stages; latches hold while gate stays low.
// - Force low drives all outputs high, or low when invert is high.
// - Force high passes latches, true when invert high, else complemented.
// - Serial output shows the last stage in the current direction.
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module s2p_driver #(
	parameter int CHANNELS = s2p_pkg::CHANNELS,
	parameter int COUNT_WIDTH = s2p_pkg::COUNT_WIDTH
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Pins from the controller.
	input wire logic shift_clock_in,
	input wire logic latch_gate_in,
	input wire logic output_force_in,
	input wire logic invert_select_in,
	input wire logic shift_way_select_in,
	input wire logic serial_port_a_in,
	output logic serial_port_a_out,
	output logic serial_port_a_oe_out,
	input wire logic serial_port_b_in,
	output logic serial_port_b_out,
	output logic serial_port_b_oe_out,
	output logic [CHANNELS-1:0] driver_output_out,
	// Avalon-MM slave.
	input wire logic [s2p_pkg::ADDR_WIDTH-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [s2p_pkg::DATA_WIDTH-1:0] avs_writedata_in,
	output logic [s2p_pkg::DATA_WIDTH-1:0] avs_readdata_out,
	output logic avs_waitrequest_out
);

	// ==========================================================
	// Pin synchronisers
	logic [s2p_pkg::STAT_WIDTH-1:0] ctl_raw;
	logic [s2p_pkg::STAT_WIDTH-1:0] ctl_f;
	logic [1:0] data_f;
	logic shift_clock_f;
	logic latch_gate_f;
	logic output_force_f;
	logic invert_select_f;
	logic way_f;
	logic data_a_f;
	logic data_b_f;

	assign ctl_raw[s2p_pkg::STAT_SHIFT_CLOCK] = shift_clock_in;
	assign ctl_raw[s2p_pkg::STAT_LATCH_GATE] = latch_gate_in;
	assign ctl_raw[s2p_pkg::STAT_OUTPUT_FORCE] = output_force_in;
	assign ctl_raw[s2p_pkg::STAT_INVERT_SELECT] = invert_select_in;
	assign ctl_raw[s2p_pkg::STAT_SHIFT_WAY] = shift_way_select_in;

	s2p_sync #(
		.WIDTH(s2p_pkg::STAT_WIDTH)
	) u_ctl_sync (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.async_in(ctl_raw),
		.level_out(ctl_f)
	);

	// Data pins go through the same depth, so a bit lines up with the
	// clock edge that it was set up for.
	s2p_sync #(
		.WIDTH(2)
	) u_data_sync (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.async_in({serial_port_b_in, serial_port_a_in}),
		.level_out(data_f)
	);

	assign shift_clock_f = ctl_f[s2p_pkg::STAT_SHIFT_CLOCK];
	assign latch_gate_f = ctl_f[s2p_pkg::STAT_LATCH_GATE];
	assign output_force_f = ctl_f[s2p_pkg::STAT_OUTPUT_FORCE];
	assign invert_select_f = ctl_f[s2p_pkg::STAT_INVERT_SELECT];
	assign way_f = ctl_f[s2p_pkg::STAT_SHIFT_WAY];
	assign data_a_f = data_f[0];
	assign data_b_f = data_f[1];

	// ==========================================================
	// Shift clock edge detection
	logic shift_clock_prev;
	logic shift_edge;

	// The previous level resets high, so the first cycle after reset can
	// never count as an edge, whatever the filter shows then.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			shift_clock_prev <= s2p_pkg::SHIFT_CLOCK_PREV_RESET;
		end else begin
			shift_clock_prev <= shift_clock_f;
		end
	end

	assign shift_edge = shift_clock_f & ~shift_clock_prev;

	// ==========================================================
	// Shift register, latches and serial output
	// Bit 0 is stage 1, bit CHANNELS-1 is the last stage.
	logic [CHANNELS-1:0] shift_q;
	logic [CHANNELS-1:0] latch_q;
	logic [CHANNELS-1:0] next_shift;
	logic [CHANNELS-1:0] next_latch;
	logic [CHANNELS-1:0] next_drive;
	logic [CHANNELS-1:0] drive_q;
	logic next_port_a;
	logic next_port_b;
	logic port_a_q;
	logic port_b_q;

	always_comb begin
		next_shift = shift_q;
		if (shift_edge) begin
			if (way_f) begin
				next_shift = {shift_q[CHANNELS-2:0], data_b_f};
			end else begin
				next_shift = {data_a_f, shift_q[CHANNELS-1:1]};
			end
		end
		// A transparent latch takes the new stage value in the same edge,
		// so the outputs track shifting without a cycle of lag.
		next_latch = latch_gate_f ? next_shift : latch_q;
		next_port_a = next_shift[CHANNELS-1];
		next_port_b = next_shift[0];
	end

	s2p_outstage #(
		.WIDTH(CHANNELS)
	) u_outstage (
		.output_force_in(output_force_f),
		.invert_select_in(invert_select_f),
		.latch_in(next_latch),
		.drive_out(next_drive)
	);

	// No reset here on purpose: the pattern is meaningless until the
	// controller has loaded and latched one.
	always_ff @(posedge sys_clk_in) begin
		shift_q <= next_shift;
		latch_q <= next_latch;
		drive_q <= next_drive;
		port_a_q <= next_port_a;
		port_b_q <= next_port_b;
	end

	// The port that is not the serial input is the driven one.
	assign serial_port_a_out = port_a_q;
	assign serial_port_a_oe_out = way_f;
	assign serial_port_b_out = port_b_q;
	assign serial_port_b_oe_out = ~way_f;
	assign driver_output_out = drive_q;

	// ==========================================================
	// Shift edge counter and control
	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	logic [COUNT_WIDTH-1:0] edge_count;
	logic [COUNT_WIDTH-1:0] next_edge_count;
	logic ctrl_write;

	always_comb begin
		next_ctrl = ctrl;
		next_ctrl[s2p_pkg::CTRL_COUNT_CLEAR] = 1'b0;
		if (ctrl_write && avs_byteenable_in[0]) begin
			next_ctrl = avs_writedata_in[1:0];
		end
		next_edge_count = edge_count;
		// A clear overrides an edge in the same cycle; the count is a
		// statistic, not a flag, so losing one edge is acceptable.
		if (ctrl[s2p_pkg::CTRL_COUNT_CLEAR]) begin
			next_edge_count = '0;
		end else if (shift_edge && !ctrl[s2p_pkg::CTRL_COUNT_FREEZE]) begin
			next_edge_count = edge_count + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			ctrl <= s2p_pkg::CTRL_RESET;
			edge_count <= COUNT_WIDTH'(s2p_pkg::COUNT_RESET);
		end else begin
			ctrl <= next_ctrl;
			edge_count <= next_edge_count;
		end
	end

	// ==========================================================
	// Avalon-MM slave
	// Every access takes exactly one wait cycle, then is answered.
	s2p_pkg::s2p_bus_state_t bus_state;
	s2p_pkg::s2p_bus_state_t next_bus_state;
	logic [s2p_pkg::DATA_WIDTH-1:0] readdata;
	logic [s2p_pkg::DATA_WIDTH-1:0] next_readdata;
	logic bus_req;

	assign bus_req = avs_read_in | avs_write_in;
	assign ctrl_write = avs_write_in && (bus_state == s2p_pkg::S2P_BUS_ANSWER)
		&& (avs_address_in == s2p_pkg::REG_CTRL);

	always_comb begin
		next_bus_state = bus_state;
		next_readdata = readdata;
		case (bus_state)
			s2p_pkg::S2P_BUS_IDLE: begin
				if (bus_req) begin
					next_bus_state = s2p_pkg::S2P_BUS_ANSWER;
					case (avs_address_in)
						s2p_pkg::REG_CTRL: begin
							next_readdata = {30'h0, ctrl};
						end
						s2p_pkg::REG_STATUS: begin
							next_readdata = {27'h0, ctl_f};
						end
						s2p_pkg::REG_SHIFT_LO: begin
							next_readdata = shift_q[31:0];
						end
						s2p_pkg::REG_SHIFT_HI: begin
							next_readdata = shift_q[63:32];
						end
						s2p_pkg::REG_LATCH_LO: begin
							next_readdata = latch_q[31:0];
						end
						s2p_pkg::REG_LATCH_HI: begin
							next_readdata = latch_q[63:32];
						end
						s2p_pkg::REG_EDGE_COUNT: begin
							next_readdata = 32'(edge_count);
						end
						default: begin
							next_readdata = s2p_pkg::READ_UNMAPPED;
						end
					endcase
				end
			end
			s2p_pkg::S2P_BUS_ANSWER: begin
				next_bus_state = s2p_pkg::S2P_BUS_IDLE;
			end
			default: begin
				next_bus_state = s2p_pkg::S2P_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			bus_state <= s2p_pkg::S2P_BUS_IDLE;
			readdata <= s2p_pkg::READ_UNMAPPED;
		end else begin
			bus_state <= next_bus_state;
			readdata <= next_readdata;
		end
	end

	assign avs_waitrequest_out = bus_req && (bus_state == s2p_pkg::S2P_BUS_IDLE);
	assign avs_readdata_out = readdata;

	// ==========================================================
	// Assertions
	logic [CHANNELS-1:0] fwd_expect;
	logic [CHANNELS-1:0] rev_expect;

	assign fwd_expect = {shift_q[CHANNELS-2:0], data_b_f};
	assign rev_expect = {data_a_f, shift_q[CHANNELS-1:1]};

	sequence seq_gate_fall;
		latch_gate_f ##1 !latch_gate_f;
	endsequence

	sequence seq_edge_fwd;
		shift_edge && way_f;
	endsequence

	sequence seq_edge_rev;
		shift_edge && !way_f;
	endsequence

	a_shift_forward: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		seq_edge_fwd |=> shift_q === $past(fwd_expect))
		else $error("forward shift did not move stage 1 toward 64");

	a_shift_reverse: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		seq_edge_rev |=> shift_q === $past(rev_expect))
		else $error("reverse shift did not move stage 64 toward 1");

	a_shift_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!shift_edge |=> shift_q === $past(shift_q))
		else $error("shift register moved without a clock edge");

	a_shift_ignores_ctl: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(shift_edge && (!latch_gate_f || !output_force_f))
		|=> shift_q === $past(way_f ? fwd_expect : rev_expect))
		else $error("shifting was disturbed by latch or output controls");

	a_latch_follow: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		latch_gate_f |=> latch_q === shift_q)
		else $error("transparent latch did not follow its stage");

	a_latch_capture: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		seq_gate_fall ##1 !latch_gate_f
		|-> latch_q === $past(latch_q, 1) && latch_q === $past(shift_q, 1))
		else $error("latch did not hold the value captured at the gate fall");

	a_force_level: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!output_force_f |=> driver_output_out == {CHANNELS{~$past(invert_select_f)}})
		else $error("forced outputs do not match the invert select level");

	a_pass_pattern: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		output_force_f
		|=> driver_output_out === ($past(invert_select_f) ? latch_q : ~latch_q))
		else $error("outputs do not show the latch pattern with its polarity");

	a_serial_last: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		##1 (serial_port_a_out === shift_q[CHANNELS-1]
		&& serial_port_b_out === shift_q[0]))
		else $error("serial output does not show the last stage");

	a_bus_one_wait: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(bus_req && bus_state == s2p_pkg::S2P_BUS_IDLE) |=> !avs_waitrequest_out)
		else $error("bus access not answered after one wait cycle");

endmodule

`default_nettype wire

// ### tb/s2p_host.sv
// Controller model that drives the serial and control pins of the core.
`timescale 1ns/100ps
`default_nettype none

module s2p_host (
	input wire logic sys_clk_in,
	output logic shift_clock_out,
	output logic latch_gate_out,
	output logic output_force_out,
	output logic invert_select_out,
	output logic shift_way_select_out,
	output logic port_a_drive_out,
	output logic port_b_drive_out
);

	// ==========================================================
	// Pin levels at power-up
	initial begin
		shift_clock_out = 1'b0;
		latch_gate_out = 1'b0;
		output_force_out = 1'b0;
		invert_select_out = 1'b0;
		shift_way_select_out = 1'b0;
		port_a_drive_out = 1'b0;
		port_b_drive_out = 1'b0;
	end

	// ==========================================================
	// Pin sequences
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask

	// Every level stands four system cycles, so the three-flop filter
	// always sees it; data stays put until the clock has fallen again.
	task automatic send_bit(input logic b);
		@(posedge sys_clk_in);
		if (shift_way_select_out) begin
			port_b_drive_out <= b;
		end else begin
			port_a_drive_out <= b;
		end
		hold(4);
		shift_clock_out <= 1'b1;
		hold(4);
		shift_clock_out <= 1'b0;
		hold(4);
		// Past its hold time the data line shows the opposite level.
		if (shift_way_select_out) begin
			port_b_drive_out <= ~b;
		end else begin
			port_a_drive_out <= ~b;
		end
	endtask

	// The first bit sent ends in the stage farthest from the input.
	task automatic send_word(input logic [63:0] w);
		for (int i = 0; i < 64; i++) begin
			if (shift_way_select_out) begin
				send_bit(w[63-i]);
			end else begin
				send_bit(w[i]);
			end
		end
		hold(8);
	endtask

	task automatic set_pins(input logic gate, input logic force_lvl,
		input logic inv, input logic way);
		@(posedge sys_clk_in);
		latch_gate_out <= gate;
		output_force_out <= force_lvl;
		invert_select_out <= inv;
		shift_way_select_out <= way;
		hold(8);
	endtask

endmodule

`default_nettype wire

// ### tb/s2p_driver_bench.sv
// Self-checking bench for the serial-to-parallel driver core.
`timescale 1ns/100ps
`default_nettype none

`define S2P_CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module s2p_driver_bench;

	// ==========================================================
	// Signals
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic shift_clock, latch_gate, output_force, invert_select, way;
	logic a_drive, b_drive, a_wire, b_wire;
	logic a_out, a_oe, b_out, b_oe;
	logic [63:0] drv;
	logic [63:0] word;
	logic [31:0] rd;
	int err_count = 0;
	int tests_run = 0;
	int cycle_count = 0;
	localparam logic [63:0] P1 = 64'hf0e1_d2c3_b4a5_9687;
	localparam logic [63:0] P2 = 64'h1357_9bdf_2468_ace0;

	always #12.5 sys_clk = ~sys_clk;

	// Whoever has its enable up owns the wire.
	assign a_wire = a_oe ? a_out : a_drive;
	assign b_wire = b_oe ? b_out : b_drive;

	s2p_host host (
		.sys_clk_in(sys_clk),
		.shift_clock_out(shift_clock),
		.latch_gate_out(latch_gate),
		.output_force_out(output_force),
		.invert_select_out(invert_select),
		.shift_way_select_out(way),
		.port_a_drive_out(a_drive),
		.port_b_drive_out(b_drive)
	);

	s2p_driver uut (
		.sys_clk_in(sys_clk),
		.reset_in(reset),
		.shift_clock_in(shift_clock),
		.latch_gate_in(latch_gate),
		.output_force_in(output_force),
		.invert_select_in(invert_select),
		.shift_way_select_in(way),
		.serial_port_a_in(a_wire),
		.serial_port_a_out(a_out),
		.serial_port_a_oe_out(a_oe),
		.serial_port_b_in(b_wire),
		.serial_port_b_out(b_out),
		.serial_port_b_oe_out(b_oe),
		.driver_output_out(drv),
		.avs_address_in(avs_address),
		.avs_read_in(avs_read),
		.avs_write_in(avs_write),
		.avs_byteenable_in(avs_byteenable),
		.avs_writedata_in(avs_writedata),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out)
	);

	// ==========================================================
	// Bus access and closing
	task automatic bus_xfer(input logic we, input logic [4:0] a,
		input logic [31:0] wd, output logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= we;
		avs_read <= ~we;
		// Only the bench timeout ends a wait that never sees an answer.
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest_out !== 1'b0);
		d = avs_readdata_out;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic read_pair(input logic [4:0] a, output logic [63:0] w);
		logic [31:0] lo;
		logic [31:0] hi;
		bus_xfer(1'b0, a, 32'h0, lo);
		bus_xfer(1'b0, a + 5'h04, 32'h0, hi);
		w = {hi, lo};
	endtask

	task automatic test_done();
		if (err_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// The run needs some two thousand cycles; ten times that is a hang.
	always @(posedge sys_clk) begin
		cycle_count++;
		if (cycle_count == 20000) begin
			err_count++;
			test_done();
		end
	end

	// ==========================================================
	// Scenarios
	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		host.hold(8);
		`S2P_CHECK(drv, {64{1'b1}})
		`S2P_CHECK({a_oe, b_oe}, 2'b01)
		host.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
		`S2P_CHECK(drv, 64'h0)
		// Transparent latches, way low: the word lands as sent.
		host.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
		host.send_word(P1);
		`S2P_CHECK(drv, P1)
		`S2P_CHECK(b_out, P1[0])
		read_pair(s2p_pkg::REG_SHIFT_LO, word);
		`S2P_CHECK(word, P1)
		bus_xfer(1'b1, s2p_pkg::REG_CTRL, 32'h0000_0001, rd);
		// Gate falls, way turns round, a new word shifts behind held latches.
		host.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
		`S2P_CHECK({a_oe, b_oe}, 2'b10)
		host.send_word(P2);
		`S2P_CHECK(drv, P1)
		`S2P_CHECK(a_out, P2[63])
		read_pair(s2p_pkg::REG_SHIFT_LO, word);
		`S2P_CHECK(word, P2)
		read_pair(s2p_pkg::REG_LATCH_LO, word);
		`S2P_CHECK(word, P1)
		bus_xfer(1'b0, s2p_pkg::REG_EDGE_COUNT, 32'h0, rd);
		`S2P_CHECK(rd, 32'h0000_0040)
		host.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
		`S2P_CHECK(drv, ~P1)
		host.set_pins(1'b1, 1'b1, 1'b0, 1'b1);
		`S2P_CHECK(drv, ~P2)
		host.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
		`S2P_CHECK(drv, P2)
		// One clock edge moves every stage by exactly one place.
		host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
		host.send_bit(1'b0);
		host.hold(8);
		`S2P_CHECK(drv, {P2[62:0], 1'b0})
		`S2P_CHECK(a_out, P2[62])
		// Force and invert toggle with no clock: the stages must not move.
		host.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
		`S2P_CHECK(drv, {64{1'b1}})
		read_pair(s2p_pkg::REG_SHIFT_LO, word);
		`S2P_CHECK(word, {P2[62:0], 1'b0})
		bus_xfer(1'b1, s2p_pkg::REG_CTRL, 32'h0000_0002, rd);
		bus_xfer(1'b0, s2p_pkg::REG_CTRL, 32'h0, rd);
		`S2P_CHECK(rd, 32'h0000_0002)
		host.send_bit(1'b1);
		host.hold(8);
		// A clear written with lane 0 disabled must leave control alone.
		avs_byteenable <= 4'he;
		bus_xfer(1'b1, s2p_pkg::REG_CTRL, 32'h0000_0001, rd);
		avs_byteenable <= 4'hf;
		bus_xfer(1'b0, s2p_pkg::REG_EDGE_COUNT, 32'h0, rd);
		`S2P_CHECK(rd, 32'h0000_0041)
		bus_xfer(1'b1, s2p_pkg::REG_STATUS, 32'hffff_ffff, rd);
		bus_xfer(1'b0, s2p_pkg::REG_STATUS, 32'h0, rd);
		`S2P_CHECK(rd, 32'h0000_0012)
		bus_xfer(1'b0, 5'h1c, 32'h0, rd);
		`S2P_CHECK(rd, s2p_pkg::READ_UNMAPPED)
		test_done();
	end

endmodule

`default_nettype wire
